// >>> logic/chr_consts.svh
// Purpose: offsets, field positions and reset values of the card host register map
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: response words occupy four consecutive words from their base
`ifndef CHR_CONSTS_SVH
`define CHR_CONSTS_SVH
`define CHR_ADDR_W 14
`define CHR_OFF_IRQ_RAW 14'h0000
`define CHR_OFF_IRQ_MASK 14'h0004
`define CHR_OFF_IRQ_CLEAR 14'h0008
`define CHR_OFF_CLK_RATE 14'h000c
`define CHR_OFF_CONFIG 14'h0010
`define CHR_OFF_XFER_CTRL 14'h0014
`define CHR_OFF_ARG 14'h0018
`define CHR_OFF_CMD 14'h001c
`define CHR_OFF_CMD_REPLY 14'h0020
`define CHR_OFF_REPLY0 14'h0024
`define CHR_OFF_REPLY3 14'h0030
`define CHR_OFF_Q_STATUS 14'h0034
`define CHR_OFF_Q_THRESH 14'h0038
`define CHR_OFF_TXQ_BASE 14'h1000
`define CHR_OFF_RXQ_BASE 14'h2000
`define CHR_WIN_MASK 14'h3000
`define CHR_BIT_LINE3 19
`define CHR_BIT_SDIO 18
`define CHR_BIT_DATA_DONE 17
`define CHR_BIT_DATA_CRC 16
`define CHR_BIT_REPLY 15
`define CHR_SRC_LO 15
`define CHR_SRC_HI 19
`define CHR_THRESH_RESET 32'h00004040
`define CHR_ZERO32 32'h00000000
`endif

// >>> logic/chr_pkg.sv
// Purpose: shared types of the card host register map
// Assumes: constants come from chr_consts.svh
// Notes: none
package chr_pkg;
  typedef enum logic [1:0] {
    CHR_IDLE,
    CHR_ACK
  } chr_bus_state_t;
  typedef logic [4:0] chr_src_t;
endpackage

// >>> logic/chr_regmap.sv
// Purpose: card host controller register map with raw interrupt source
// Assumes: card engine events arrive as one-cycle pulses on CLK
// Notes: queue windows are passed through as strobes to the queues outside
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "chr_consts.svh"
module chr_regmap
  import chr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`CHR_ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire logic CARD_DATA_LINE_THREE,
  input wire logic SDIO_CARD_IRQ,
  input wire logic DATA_DONE_EVT,
  input wire logic DATA_CRC_EVT,
  input wire logic REPLY_EVT,
  input wire logic [31:0] CMD_REPLY,
  input wire logic [127:0] REPLY_WORDS,
  input wire logic [31:0] QUEUE_LEVEL,
  input wire logic [31:0] RXQ_DATA,
  output logic [31:0] CLK_RATE,
  output logic [31:0] CARD_CONFIG,
  output logic [31:0] XFER_CTRL,
  output logic [31:0] CMD_ARG,
  output logic [31:0] CMD_ISSUE,
  output logic CMD_ISSUE_STB,
  output logic [31:0] QUEUE_THRESH,
  output logic QUEUE_CTRL_STB,
  output logic [31:0] QUEUE_CTRL_DATA,
  output logic TXQ_PUSH,
  output logic [31:0] TXQ_DATA,
  output logic RXQ_POP,
  output logic IRQ
);
  chr_bus_state_t state;
  chr_src_if src ();
  logic [1:0] line3_sync;
  logic [1:0] sdio_sync;
  logic [31:0] irq_mask;
  logic req;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] next_rdata;
  logic [31:0] wmask;
  logic [31:0] raw_word;
  logic [`CHR_ADDR_W-1:0] win;
  logic [`CHR_ADDR_W-1:0] word_adr;
  logic [31:0] irq_pending;
  logic [1:0] reply_idx;
  logic in_regs;
  logic in_txq;
  logic in_rxq;
  logic sel_mask;
  logic sel_clear;
  logic sel_clk_rate;
  logic sel_config;
  logic sel_xfer;
  logic sel_arg;
  logic sel_cmd;
  logic sel_q_status;
  logic sel_q_thresh;

  // bit 19 is status only, so it never reaches the pin
  localparam logic [31:0] irq_sources = (32'h00000001 << `CHR_BIT_SDIO) |
    (32'h00000001 << `CHR_BIT_DATA_DONE) |
    (32'h00000001 << `CHR_BIT_DATA_CRC) |
    (32'h00000001 << `CHR_BIT_REPLY);

  // pins from the card pass two flops before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      line3_sync <= 2'h0;
      sdio_sync <= 2'h0;
    end else begin
      line3_sync <= {line3_sync[0], CARD_DATA_LINE_THREE};
      sdio_sync <= {sdio_sync[0], SDIO_CARD_IRQ};
    end
  end

  // a new request only in idle, so each access gets one ack or one err
  assign req = WB_CYC_I && WB_STB_I && (state == CHR_IDLE);
  assign wr = req && WB_WE_I;
  assign rd = req && !WB_WE_I;
  assign win = WB_ADR_I & `CHR_WIN_MASK;
  assign word_adr = {WB_ADR_I[`CHR_ADDR_W-1:2], 2'h0};
  assign in_regs = (win == 14'h0000);
  assign in_txq = (win == `CHR_OFF_TXQ_BASE);
  assign in_rxq = (win == `CHR_OFF_RXQ_BASE);

  // one select per writable word, low window only
  assign sel_mask = in_regs && (word_adr == `CHR_OFF_IRQ_MASK);
  assign sel_clear = in_regs && (word_adr == `CHR_OFF_IRQ_CLEAR);
  assign sel_clk_rate = in_regs && (word_adr == `CHR_OFF_CLK_RATE);
  assign sel_config = in_regs && (word_adr == `CHR_OFF_CONFIG);
  assign sel_xfer = in_regs && (word_adr == `CHR_OFF_XFER_CTRL);
  assign sel_arg = in_regs && (word_adr == `CHR_OFF_ARG);
  assign sel_cmd = in_regs && (word_adr == `CHR_OFF_CMD);
  assign sel_q_status = in_regs && (word_adr == `CHR_OFF_Q_STATUS);
  assign sel_q_thresh = in_regs && (word_adr == `CHR_OFF_Q_THRESH);

  // reply word n sits one word above its address bits, wraps at the last
  assign reply_idx = WB_ADR_I[3:2] - 2'h1;

  // byte enables widened to bit masks, one lane at a time
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wmask[8*lane +: 8] = {8{WB_SEL_I[lane]}};
    end
  endgenerate

  // byte-lane merge shared by the mask and every control register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
    input logic [31:0] lanes);
    lane_merge = (old_val & ~lanes) | (new_val & lanes);
  endfunction

  // source word at offset zero, upper bits zero
  assign raw_word = {12'h000, src.raw, 15'h0000};

  assign src.event_in = {2'h0, DATA_DONE_EVT, DATA_CRC_EVT, REPLY_EVT};
  assign src.clear_mask = (wr && sel_clear) ?
    (WB_DAT_I[`CHR_SRC_HI:`CHR_SRC_LO] & wmask[`CHR_SRC_HI:`CHR_SRC_LO]) : 5'h00;

  chr_src_latch u_latch (
    .clk(CLK),
    .rst_n(RST_N),
    .line3_level(line3_sync[1]),
    .sdio_level(sdio_sync[1]),
    .src(src.latch)
  );

  always_comb begin
    hit = 1'b1;
    next_rdata = `CHR_ZERO32;
    if (in_txq) begin
      hit = WB_WE_I;
    end else if (in_rxq) begin
      hit = !WB_WE_I;
      next_rdata = RXQ_DATA;
    end else begin
      case (word_adr)
        `CHR_OFF_IRQ_RAW: begin
          hit = !WB_WE_I;
          next_rdata = raw_word;
        end
        `CHR_OFF_IRQ_MASK: next_rdata = irq_mask;
        `CHR_OFF_IRQ_CLEAR: hit = WB_WE_I;
        `CHR_OFF_CLK_RATE: next_rdata = CLK_RATE;
        `CHR_OFF_CONFIG: next_rdata = CARD_CONFIG;
        `CHR_OFF_XFER_CTRL: next_rdata = XFER_CTRL;
        `CHR_OFF_ARG: next_rdata = CMD_ARG;
        `CHR_OFF_CMD: next_rdata = CMD_ISSUE;
        `CHR_OFF_CMD_REPLY: begin
          hit = !WB_WE_I;
          next_rdata = CMD_REPLY;
        end
        `CHR_OFF_Q_STATUS: next_rdata = QUEUE_LEVEL;
        `CHR_OFF_Q_THRESH: next_rdata = QUEUE_THRESH;
        default: begin
          if (word_adr >= `CHR_OFF_REPLY0 && word_adr <= `CHR_OFF_REPLY3) begin
            hit = !WB_WE_I;
            next_rdata = REPLY_WORDS[32*reply_idx +: 32];
          end else begin
            hit = 1'b0;
          end
        end
      endcase
    end
  end

  // idle after every answer, so a held request is not taken twice
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= CHR_IDLE;
    end else begin
      case (state)
        CHR_IDLE: begin
          if (req) begin
            state <= CHR_ACK;
          end
        end
        CHR_ACK: state <= CHR_IDLE;
        default: state <= CHR_IDLE;
      endcase
    end
  end

  // one wait-free answer: ack or err the edge after the request
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && hit;
      WB_ERR_O <= req && !hit;
    end
  end

  // read data holds until the next access
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_DAT_O <= `CHR_ZERO32;
    end else if (req) begin
      WB_DAT_O <= hit ? next_rdata : `CHR_ZERO32;
    end
  end

  // mask resets to zero: no source reaches the pin until enabled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask <= `CHR_ZERO32;
    end else if (wr && sel_mask) begin
      irq_mask <= lane_merge(irq_mask, WB_DAT_I, wmask);
    end
  end

  // control registers; byte lanes honoured
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLK_RATE <= `CHR_ZERO32;
    end else if (wr && sel_clk_rate) begin
      CLK_RATE <= lane_merge(CLK_RATE, WB_DAT_I, wmask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CARD_CONFIG <= `CHR_ZERO32;
    end else if (wr && sel_config) begin
      CARD_CONFIG <= lane_merge(CARD_CONFIG, WB_DAT_I, wmask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      XFER_CTRL <= `CHR_ZERO32;
    end else if (wr && sel_xfer) begin
      XFER_CTRL <= lane_merge(XFER_CTRL, WB_DAT_I, wmask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CMD_ARG <= `CHR_ZERO32;
    end else if (wr && sel_arg) begin
      CMD_ARG <= lane_merge(CMD_ARG, WB_DAT_I, wmask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CMD_ISSUE <= `CHR_ZERO32;
    end else if (wr && sel_cmd) begin
      CMD_ISSUE <= lane_merge(CMD_ISSUE, WB_DAT_I, wmask);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      QUEUE_THRESH <= `CHR_THRESH_RESET;
    end else if (wr && sel_q_thresh) begin
      QUEUE_THRESH <= lane_merge(QUEUE_THRESH, WB_DAT_I, wmask);
    end
  end

  // strobes to the card engine and queues, one cycle each
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CMD_ISSUE_STB <= 1'b0;
    end else begin
      CMD_ISSUE_STB <= wr && sel_cmd;
    end
  end

  // flush meaning is left to the queues outside
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      QUEUE_CTRL_STB <= 1'b0;
      QUEUE_CTRL_DATA <= `CHR_ZERO32;
    end else begin
      QUEUE_CTRL_STB <= wr && sel_q_status;
      if (wr && sel_q_status) begin
        QUEUE_CTRL_DATA <= WB_DAT_I & wmask;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TXQ_PUSH <= 1'b0;
      TXQ_DATA <= `CHR_ZERO32;
    end else begin
      TXQ_PUSH <= wr && in_txq;
      if (wr && in_txq) begin
        TXQ_DATA <= WB_DAT_I & wmask;
      end
    end
  end

  // pop after the read so the sampled word is the head
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RXQ_POP <= 1'b0;
    end else begin
      RXQ_POP <= rd && in_rxq;
    end
  end

  assign irq_pending = raw_word & irq_mask & irq_sources;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |irq_pending;
    end
  end
endmodule

// >>> logic/chr_src_if.sv
// Purpose: carries the raw source bits between the register bank and the source latch
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
interface chr_src_if;
  logic [4:0] event_in;
  logic [4:0] clear_mask;
  logic [4:0] raw;
  modport bank (output event_in, output clear_mask, input raw);
  modport latch (input event_in, input clear_mask, output raw);
endinterface

// >>> logic/chr_src_latch.sv
// Purpose: raw interrupt source bits 15 to 19, sticky for bits 15 to 17, live levels for 18 and 19
// Assumes: event_in sampled on the same clock
// Notes: index 0 is bit 15
`timescale 1ns/1ns
`include "chr_consts.svh"
module chr_src_latch
  import chr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line3_level,
  input wire logic sdio_level,
  chr_src_if.latch src
);
  logic [2:0] sticky;
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sticky
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sticky[i] <= 1'b0;
        end else if (src.event_in[i]) begin
          sticky[i] <= 1'b1;
        end else if (src.clear_mask[i]) begin
          sticky[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign src.raw = {line3_level, sdio_level, sticky};
endmodule

// >>> tb/chr_card_model.sv
// Purpose: card side pins for the register map bench
// Assumes: driven from the bench clock
// Notes: events one cycle wide
`timescale 1ns/1ns
module chr_card_model (
  input wire logic clk,
  output logic line3,
  output logic sdio,
  output logic [2:0] evt
);
  initial begin
    line3 = 1'b0;
    sdio = 1'b0;
    evt = 3'h0;
  end
  task automatic set_pins(input logic l, input logic s);
    @(posedge clk);
    line3 <= l;
    // cause held until card drops it
    sdio <= s;
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 3'h0;
  endtask
endmodule

// >>> tb/chr_regmap_properties.sv
// Purpose: port checks of the register map
// Assumes: one clock, classic bus cycles
// Notes: pins judged only when stable a few cycles
`timescale 1ns/1ns
`include "chr_consts.svh"
module chr_regmap_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`CHR_ADDR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic CARD_DATA_LINE_THREE,
  input wire logic SDIO_CARD_IRQ,
  input wire logic DATA_DONE_EVT,
  input wire logic DATA_CRC_EVT,
  input wire logic REPLY_EVT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire l3 = CARD_DATA_LINE_THREE;
  wire sd = SDIO_CARD_IRQ;
  wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  wire rd0 = tk && !WB_WE_I && WB_ADR_I == `CHR_OFF_IRQ_RAW;
  property p_answer; tk |=> WB_ACK_O != WB_ERR_O; endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");
  property p_raw_rd; rd0 |=> WB_ACK_O; endproperty
  a_raw_rd: assert property (p_raw_rd) else $error("raw read refused");
  property p_raw_ro; tk && WB_WE_I && WB_ADR_I == `CHR_OFF_IRQ_RAW |=> WB_ERR_O; endproperty
  a_raw_ro: assert property (p_raw_ro) else $error("raw write accepted");
  property p_line3; rd0 && l3 == $past(l3) && l3 == $past(l3, 2) && l3 == $past(l3, 3) |=> WB_DAT_O[19] == $past(l3); endproperty
  a_line3: assert property (p_line3) else $error("bit 19 not live level");
  property p_sdio; rd0 && sd == $past(sd) && sd == $past(sd, 2) && sd == $past(sd, 3) |=> WB_DAT_O[18] == $past(sd); endproperty
  a_sdio: assert property (p_sdio) else $error("bit 18 not card interrupt");
  property p_done; DATA_DONE_EVT ##[2:5] rd0 |=> WB_DAT_O[17]; endproperty
  a_done: assert property (p_done) else $error("bit 17 not set");
  property p_crc; DATA_CRC_EVT ##[2:5] rd0 |=> WB_DAT_O[16]; endproperty
  a_crc: assert property (p_crc) else $error("bit 16 not set");
  property p_reply; REPLY_EVT ##[2:5] rd0 |=> WB_DAT_O[15]; endproperty
  a_reply: assert property (p_reply) else $error("bit 15 not set");
  cover property (rd0 ##1 WB_DAT_O[18]);
  cover property (tk && WB_WE_I ##1 WB_ERR_O);
  cover property (DATA_DONE_EVT);
endmodule
bind chr_regmap chr_regmap_props props_u (.*);

// >>> tb/chr_regmap_tb.sv
// Purpose: register map bench
// Assumes: single 100 MHz clock
// Notes: reply and queue inputs held constant
`timescale 1ns/1ns
`include "chr_consts.svh"
module chr_regmap_tb;
  localparam logic [13:0] ra = `CHR_OFF_IRQ_RAW;
  localparam logic [13:0] ma = `CHR_OFF_IRQ_MASK;
  localparam logic [13:0] ca = `CHR_OFF_IRQ_CLEAR;
  logic CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, WB_ERR_O, CMD_ISSUE_STB;
  logic QUEUE_CTRL_STB, TXQ_PUSH, RXQ_POP, IRQ, re;
  logic [13:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, CLK_RATE, CARD_CONFIG, XFER_CTRL, CMD_ARG, CMD_ISSUE;
  logic [31:0] QUEUE_THRESH, QUEUE_CTRL_DATA, TXQ_DATA, rq, ex;
  logic [31:0] CMD_REPLY = 32'h0, QUEUE_LEVEL = 32'h0, RXQ_DATA = 32'h0000c35a;
  logic [127:0] REPLY_WORDS = 128'h44444444333333332222222211111111;
  wire CARD_DATA_LINE_THREE, SDIO_CARD_IRQ, DATA_DONE_EVT, DATA_CRC_EVT, REPLY_EVT;
  int num_errors = 0;
  int comparisons = 0;
  chr_regmap dut_u (.*);
  chr_card_model card_u (.clk(CLK), .line3(CARD_DATA_LINE_THREE), .sdio(SDIO_CARD_IRQ),
    .evt({DATA_DONE_EVT, DATA_CRC_EVT, REPLY_EVT}));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= s;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && n < 50);
    if (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: no answer, got %h expected %h", $time, 1'b0, 1'b1);
    end
    rq = WB_DAT_O;
    re = WB_ERR_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    wb(1'b0, ra, 32'h0, 4'hf);
    chk(rq, 32'h0);
    chk(QUEUE_THRESH, `CHR_THRESH_RESET);
    wb(1'b1, ra, 32'hffffffff, 4'hf);
    chk(re, 1'b1);
    wb(1'b0, 14'h003c, 32'h0, 4'hf);
    chk(re, 1'b1);
    $display("test reset done");
    // sync delay of the pins is two edges
    card_u.set_pins(1'b1, 1'b0);
    repeat (4) @(posedge CLK);
    wb(1'b1, ma, 32'h000f8000, 4'hf);
    wb(1'b0, ra, 32'h0, 4'hf);
    chk(rq, 32'h00080000);
    chk(IRQ, 1'b0);
    ex = 32'h00080000;
    for (int i = 0; i < 3; i++) begin
      card_u.pulse(3'h1 << i);
      wb(1'b0, ra, 32'h0, 4'hf);
      ex = ex | (32'h00008000 << i);
      chk(rq, ex);
      chk(IRQ, 1'b1);
    end
    // byte lane 1 only reaches bit 15
    wb(1'b1, ca, 32'h00038000, 4'h2);
    wb(1'b0, ra, 32'h0, 4'hf);
    chk(rq, 32'h000b0000);
    wb(1'b1, ca, 32'h00038000, 4'hf);
    wb(1'b0, ra, 32'h0, 4'hf);
    chk(rq, 32'h00080000);
    chk(IRQ, 1'b0);
    $display("test events done");
    card_u.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge CLK);
    wb(1'b1, ca, 32'h00040000, 4'hf);
    wb(1'b0, ra, 32'h0, 4'hf);
    chk(rq, 32'h000c0000);
    chk(IRQ, 1'b1);
    wb(1'b1, ma, 32'h00080000, 4'hf);
    wb(1'b0, ma, 32'h0, 4'hf);
    chk(rq, 32'h00080000);
    chk(IRQ, 1'b0);
    $display("test card interrupt done");
    wb(1'b1, `CHR_OFF_ARG, 32'h12345678, 4'h3);
    chk(CMD_ARG, 32'h00005678);
    wb(1'b0, ca, 32'h0, 4'hf);
    chk(re, 1'b1);
    wb(1'b1, `CHR_OFF_CLK_RATE, 32'h00000031, 4'hf);
    wb(1'b1, `CHR_OFF_CONFIG, 32'h00000102, 4'hf);
    wb(1'b1, `CHR_OFF_XFER_CTRL, 32'h00000203, 4'hf);
    wb(1'b0, `CHR_OFF_CLK_RATE, 32'h0, 4'hf);
    chk(rq, 32'h00000031);
    chk(CARD_CONFIG, 32'h00000102);
    chk(XFER_CTRL, 32'h00000203);
    wb(1'b1, `CHR_OFF_CMD, 32'h00000011, 4'hf);
    chk(CMD_ISSUE_STB, 1'b1);
    chk(CMD_ISSUE, 32'h00000011);
    wb(1'b0, `CHR_OFF_REPLY0, 32'h0, 4'hf);
    chk(rq, 32'h11111111);
    wb(1'b0, `CHR_OFF_REPLY3, 32'h0, 4'hf);
    chk(rq, 32'h44444444);
    $display("test registers done");
    wb(1'b1, `CHR_OFF_TXQ_BASE, 32'ha5a5a5a5, 4'h1);
    chk(TXQ_PUSH, 1'b1);
    chk(TXQ_DATA, 32'h000000a5);
    wb(1'b1, `CHR_OFF_Q_STATUS, 32'h80000000, 4'hf);
    chk(QUEUE_CTRL_STB, 1'b1);
    chk(QUEUE_CTRL_DATA, 32'h80000000);
    wb(1'b0, `CHR_OFF_RXQ_BASE, 32'h0, 4'hf);
    chk(rq, 32'h0000c35a);
    chk(RXQ_POP, 1'b1);
    $display("test queues done");
    finish_test;
  end
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule
